// >>> plmc_pkg.sv
// package: register map, field positions, reset values and timing counts for led and crossover control
package plmc_pkg;

  // ------------------------------------------------------------
  // register indices (printed offsets are not all multiples of 4)
  // ------------------------------------------------------------
  localparam logic [7:0] LED_CONTROL_IDX  = 8'h18;
  localparam logic [7:0] PHY_CONTROL_IDX  = 8'h19;
  localparam logic [7:0] IRQ_STATUS_IDX   = 8'h1A;
  localparam logic [7:0] IRQ_MASK_IDX     = 8'h1B;
  localparam logic [9:0] LED_CONTROL_ADDR = {LED_CONTROL_IDX, 2'b00};
  localparam logic [9:0] PHY_CONTROL_ADDR = {PHY_CONTROL_IDX, 2'b00};
  localparam logic [9:0] IRQ_STATUS_ADDR  = {IRQ_STATUS_IDX, 2'b00};
  localparam logic [9:0] IRQ_MASK_ADDR    = {IRQ_MASK_IDX, 2'b00};

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BLINK_LSB     = 9;
  localparam int LED_POL_BIT   = 7;
  localparam int DRIVE_LED_BIT = 4;
  localparam int FORCE_VAL_BIT = 1;
  localparam int AUTO_X_BIT    = 15;
  localparam int FORCE_X_BIT   = 14;
  localparam int PAUSE_RX_BIT  = 13;
  localparam int PAUSE_TX_BIT  = 12;
  localparam int LINK_FD_BIT   = 11;
  localparam int BYPASS_BIT    = 7;
  localparam int LED_CFG_BIT   = 5;
  localparam int ADV_SYM_BIT   = 10;
  localparam int ADV_ASYM_BIT  = 11;

  // ------------------------------------------------------------
  // reset values and writable masks
  // ------------------------------------------------------------
  localparam logic [15:0] LED_CONTROL_RST = 16'h0400;
  localparam logic [15:0] PHY_CONTROL_RST = 16'h8000;
  localparam logic [15:0] LED_CONTROL_WM  = 16'h07FF;
  localparam logic [15:0] PHY_CONTROL_WM  = 16'hC0E0;
  localparam logic [2:0]  IRQ_RST         = 3'h0;
  localparam logic [1:0]  BLINK_RST       = 2'h2;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ        = 25_000_000;
  localparam int BLINK_MS_0    = 50;
  localparam int BLINK_MS_1    = 100;
  localparam int BLINK_MS_2    = 200;
  localparam int BLINK_MS_3    = 500;
  localparam int TICK_US       = 1000;
  localparam int TICK_CYC      = CLK_HZ / 1_000_000 * TICK_US;
  localparam int STRETCH_MS    = 50;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic       mode_ext;
    logic       led_pol;
    logic       auto_x;
    logic       force_x;
    logic [4:0] phy_addr;
  } plmc_strap_t;

  typedef struct packed {
    logic       an_done;
    logic       full_duplex;
    logic       speed_100;
    logic       link_up;
    logic [1:0] local_pause;
    logic [1:0] partner_pause;
  } plmc_an_t;

endpackage : plmc_pkg

// >>> plmc_blink.sv
// blink and pulse-stretch timer driven by a millisecond tick
`timescale 1ns/1ns
module plmc_blink #(
  parameter int TICK_CYC = plmc_pkg::TICK_CYC
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [1:0] rate,
  input  wire logic       activity,
  output logic            blink_phase,
  output logic            stretched
);

  logic [15:0] tick_cnt_r;
  logic        tick;
  logic [9:0]  ms_cnt_r;
  logic [9:0]  half_ms;
  logic [9:0]  str_cnt_r;

  assign tick = (tick_cnt_r == 16'(TICK_CYC - 1));

  always_comb begin
    case (rate)
      2'h0:    half_ms = 10'(plmc_pkg::BLINK_MS_0);
      2'h1:    half_ms = 10'(plmc_pkg::BLINK_MS_1);
      2'h2:    half_ms = 10'(plmc_pkg::BLINK_MS_2);
      default: half_ms = 10'(plmc_pkg::BLINK_MS_3);
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tick_cnt_r <= 16'h0000;
    else if (tick) tick_cnt_r <= 16'h0000;
    else tick_cnt_r <= tick_cnt_r + 16'h0001;
  end

  // on/off duration per rate code
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt_r    <= 10'h000;
      blink_phase <= 1'b0;
    end else if (tick) begin
      if (ms_cnt_r >= half_ms - 10'h001) begin // RL1
        ms_cnt_r    <= 10'h000;
        blink_phase <= ~blink_phase;
      end else begin
        ms_cnt_r <= ms_cnt_r + 10'h001;
      end
    end
  end

  // holds short activity pulses long enough to be seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) str_cnt_r <= 10'h000;
    else if (activity) str_cnt_r <= 10'(plmc_pkg::STRETCH_MS);
    else if (tick && str_cnt_r != 10'h000) str_cnt_r <= str_cnt_r - 10'h001;
  end

  assign stretched = activity | (str_cnt_r != 10'h000);

endmodule : plmc_blink

// >>> plmc_top.sv
// led and crossover control registers with ahb-lite slave and interrupt
//
// Functional notes
// RL1 - blink rate code selects 50/100/200/500 ms
// RL2 - led polarity: strap or low, bit overrides
// RL3 - drive bit puts force value on led
// RL4 - force value 0 low, 1 high
// RL5 - auto crossover resets 1, strap in extended
// RL6 - forced crossover swaps transmit and receive pairs
// RL7 - forced crossover loads strap when auto strapped off
// RL8 - pause receive from resolution, full duplex only
// RL9 - pause transmit from resolution, full duplex only
// RL10 - link bit set for negotiated 100 full duplex
// RL11 - stretch bypass shows raw led signal
// RL12 - phy address loaded from straps, readable
// RL13 - reserved read zero, led config only stored
`timescale 1ns/1ns
module plmc_top (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire plmc_pkg::plmc_strap_t strap_pins,
  input  wire plmc_pkg::plmc_an_t    an_state,
  input  wire logic                  link_activity,
  output logic                       first_led_pin,
  output logic                       pair_swap,
  output logic                       auto_crossover_en,
  output logic                       pause_rx_en,
  output logic                       pause_tx_en,
  output logic                       irq
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  plmc_pkg::plmc_strap_t strap_s1_r;
  plmc_pkg::plmc_strap_t strap_s2_r;
  plmc_pkg::plmc_an_t    an_s1_r;
  plmc_pkg::plmc_an_t    an_s2_r;
  logic                  act_s1_r;
  logic                  act_s2_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_s1_r <= '0;
      strap_s2_r <= '0;
      an_s1_r    <= '0;
      an_s2_r    <= '0;
      act_s1_r   <= 1'b0;
      act_s2_r   <= 1'b0;
    end else begin
      strap_s1_r <= strap_pins;
      strap_s2_r <= strap_s1_r;
      an_s1_r    <= an_state;
      an_s2_r    <= an_s1_r;
      act_s1_r   <= link_activity;
      act_s2_r   <= act_s1_r;
    end
  end

  // ------------------------------------------------------------
  // strap capture after reset release
  // ------------------------------------------------------------
  // synchroniser needs two edges to fill; latch on the third
  logic [1:0] strap_wait_r;
  logic       strap_load;
  logic       strap_pol_r;
  logic [4:0] phy_addr_r;

  assign strap_load = (strap_wait_r == 2'h2);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) strap_wait_r <= 2'h0;
    else if (strap_wait_r != 2'h3) strap_wait_r <= strap_wait_r + 2'h1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_pol_r <= 1'b0;
      phy_addr_r  <= 5'h00;
    end else if (strap_load) begin
      strap_pol_r <= strap_s2_r.mode_ext & strap_s2_r.led_pol; // RL2
      phy_addr_r  <= strap_s2_r.phy_addr; // RL12
    end
  end

  // ------------------------------------------------------------
  // ahb-lite slave
  // ------------------------------------------------------------
  logic       dp_valid_r;
  logic       dp_write_r;
  logic [9:0] dp_addr_r;
  logic       ap_take;

  assign ap_take   = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r  <= 10'h000;
    end else if (hready) begin
      dp_valid_r <= ap_take;
      dp_write_r <= hwrite;
      dp_addr_r  <= haddr[9:0];
    end
  end

  logic wr_led;
  logic wr_phy;
  logic wr_mask;
  logic rd_stat;

  always_comb begin
    wr_led  = 1'b0;
    wr_phy  = 1'b0;
    wr_mask = 1'b0;
    rd_stat = 1'b0;
    if (dp_valid_r && dp_write_r && dp_addr_r == plmc_pkg::LED_CONTROL_ADDR) begin
      wr_led = 1'b1;
    end else if (dp_valid_r && dp_write_r && dp_addr_r == plmc_pkg::PHY_CONTROL_ADDR) begin
      wr_phy = 1'b1;
    end else if (dp_valid_r && dp_write_r && dp_addr_r == plmc_pkg::IRQ_MASK_ADDR) begin
      wr_mask = 1'b1;
    end else if (dp_valid_r && !dp_write_r && dp_addr_r == plmc_pkg::IRQ_STATUS_ADDR) begin
      rd_stat = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  logic [15:0] led_control_r;
  logic [15:0] phy_ctl_rw_r;
  logic        strap_loaded_r;

  // writes land only in writable bits; reserved r/w bits just store
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led_control_r <= plmc_pkg::LED_CONTROL_RST; // RL1
    end else if (strap_load) begin
      led_control_r[plmc_pkg::LED_POL_BIT] <= strap_s2_r.mode_ext & strap_s2_r.led_pol; // RL2
    end else if (wr_led) begin
      led_control_r <= hwdata[15:0] & plmc_pkg::LED_CONTROL_WM; // RL13
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phy_ctl_rw_r   <= plmc_pkg::PHY_CONTROL_RST & plmc_pkg::PHY_CONTROL_WM; // RL5
      strap_loaded_r <= 1'b0;
    end else if (strap_load) begin
      strap_loaded_r <= 1'b1;
      if (strap_s2_r.mode_ext) begin
        phy_ctl_rw_r[plmc_pkg::AUTO_X_BIT] <= strap_s2_r.auto_x; // RL5
        if (!strap_s2_r.auto_x) begin
          phy_ctl_rw_r[plmc_pkg::FORCE_X_BIT] <= strap_s2_r.force_x; // RL7
        end
      end
    end else if (wr_phy) begin
      phy_ctl_rw_r <= hwdata[15:0] & plmc_pkg::PHY_CONTROL_WM; // RL13
    end
  end

  // ------------------------------------------------------------
  // negotiated status
  // ------------------------------------------------------------
  logic fd_ok;
  logic l_sym;
  logic l_asym;
  logic p_sym;
  logic p_asym;
  logic pause_rx_nxt;
  logic pause_tx_nxt;
  logic link_fd_nxt;
  logic pause_rx_r;
  logic pause_tx_r;
  logic link_fd_r;

  assign fd_ok  = an_s2_r.an_done & an_s2_r.full_duplex;
  assign l_sym  = an_s2_r.local_pause[0];
  assign l_asym = an_s2_r.local_pause[1];
  assign p_sym  = an_s2_r.partner_pause[0];
  assign p_asym = an_s2_r.partner_pause[1];

  // standard pause resolution table
  always_comb begin
    pause_rx_nxt = fd_ok & ((l_sym & p_sym) | (l_sym & l_asym & ~p_sym & p_asym)); // RL8
    pause_tx_nxt = fd_ok & ((l_sym & p_sym) | (~l_sym & l_asym & p_sym & p_asym)); // RL9
    link_fd_nxt  = fd_ok & an_s2_r.speed_100 & an_s2_r.link_up; // RL10
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pause_rx_r <= 1'b0;
      pause_tx_r <= 1'b0;
      link_fd_r  <= 1'b0;
    end else begin
      pause_rx_r <= pause_rx_nxt;
      pause_tx_r <= pause_tx_nxt;
      link_fd_r  <= link_fd_nxt;
    end
  end

  // ------------------------------------------------------------
  // interrupt: link change, pause change, strap load done
  // ------------------------------------------------------------
  logic [2:0] irq_status_r;
  logic [2:0] irq_mask_r;
  logic [2:0] irq_event;

  assign irq_event = {strap_load,
                      (pause_rx_r ^ pause_rx_nxt) | (pause_tx_r ^ pause_tx_nxt),
                      link_fd_r ^ link_fd_nxt};

  // a new event in the clearing read cycle survives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) irq_status_r <= plmc_pkg::IRQ_RST;
    else irq_status_r <= (rd_stat ? 3'h0 : irq_status_r) | irq_event;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) irq_mask_r <= plmc_pkg::IRQ_RST;
    else if (wr_mask) irq_mask_r <= hwdata[2:0];
  end

  assign irq = |(irq_status_r & irq_mask_r);

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  logic [15:0] phy_control_view;

  always_comb begin
    phy_control_view = phy_ctl_rw_r;
    phy_control_view[plmc_pkg::PAUSE_RX_BIT] = pause_rx_r; // RL8
    phy_control_view[plmc_pkg::PAUSE_TX_BIT] = pause_tx_r; // RL9
    phy_control_view[plmc_pkg::LINK_FD_BIT]  = link_fd_r; // RL10
    phy_control_view[4:0] = phy_addr_r; // RL12
  end

  // unmapped addresses read zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dp_valid_r && !dp_write_r && dp_addr_r == plmc_pkg::LED_CONTROL_ADDR) begin
      hrdata = {16'h0000, led_control_r};
    end else if (dp_valid_r && !dp_write_r && dp_addr_r == plmc_pkg::PHY_CONTROL_ADDR) begin
      hrdata = {16'h0000, phy_control_view};
    end else if (dp_valid_r && !dp_write_r && dp_addr_r == plmc_pkg::IRQ_STATUS_ADDR) begin
      hrdata = {29'h0000_0000, irq_status_r};
    end else if (dp_valid_r && !dp_write_r && dp_addr_r == plmc_pkg::IRQ_MASK_ADDR) begin
      hrdata = {29'h0000_0000, irq_mask_r};
    end
  end

  // ------------------------------------------------------------
  // led path
  // ------------------------------------------------------------
  logic blink_phase;
  logic stretched;
  logic led_level;
  logic led_nxt;

  plmc_blink u_blink (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .rate        (led_control_r[plmc_pkg::BLINK_LSB +: 2]),
    .activity    (act_s2_r),
    .blink_phase (blink_phase),
    .stretched   (stretched)
  );

  always_comb begin
    if (phy_ctl_rw_r[plmc_pkg::BYPASS_BIT]) led_level = act_s2_r; // RL11
    else led_level = link_fd_r | an_s2_r.link_up ? (~stretched | blink_phase) & an_s2_r.link_up : 1'b0;
    if (led_control_r[plmc_pkg::DRIVE_LED_BIT]) begin
      led_nxt = led_control_r[plmc_pkg::FORCE_VAL_BIT]; // RL3 RL4
    end else begin
      led_nxt = led_control_r[plmc_pkg::LED_POL_BIT] ? led_level : ~led_level; // RL2
    end
  end

  // ------------------------------------------------------------
  // outputs from flip-flops
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_led_pin     <= 1'b1;
      pair_swap         <= 1'b0;
      auto_crossover_en <= 1'b1;
      pause_rx_en       <= 1'b0;
      pause_tx_en       <= 1'b0;
    end else begin
      first_led_pin     <= led_nxt;
      pair_swap         <= phy_ctl_rw_r[plmc_pkg::FORCE_X_BIT]; // RL6
      auto_crossover_en <= phy_ctl_rw_r[plmc_pkg::AUTO_X_BIT]; // RL5
      pause_rx_en       <= pause_rx_r;
      pause_tx_en       <= pause_tx_r;
    end
  end

endmodule : plmc_top

// >>> plmc_monitor.sv
// concurrent checks on the ports of the led and crossover control block
`timescale 1ns/1ns
module plmc_monitor (
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic               hsel,
  input wire logic [31:0]        haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic [31:0]        hwdata,
  input wire logic               hready,
  input wire logic [31:0]        hrdata,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire plmc_pkg::plmc_an_t an_state,
  input wire logic               first_led_pin,
  input wire logic               pair_swap,
  input wire logic               auto_crossover_en,
  input wire logic               pause_rx_en,
  input wire logic               pause_tx_en,
  input wire logic               irq
);
  logic        dph_r;
  logic        dwr_r;
  logic [9:0]  da_r;
  logic [15:0] wd_r;
  logic        rd_led;
  logic        rd_phy;
  logic        wr_led;
  logic        wr_phy;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ------------------------------------------------------------
  // data phase tracking
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_r <= 1'b0;
      dwr_r <= 1'b0;
      da_r  <= 10'h000;
      wd_r  <= 16'h0000;
    end else if (hready) begin
      dph_r <= hsel & htrans[1];
      dwr_r <= hwrite;
      da_r  <= haddr[9:0];
      if (dph_r && dwr_r) begin
        wd_r <= hwdata[15:0];
      end
    end
  end

  assign rd_led = dph_r & ~dwr_r & (da_r == plmc_pkg::LED_CONTROL_ADDR);
  assign rd_phy = dph_r & ~dwr_r & (da_r == plmc_pkg::PHY_CONTROL_ADDR);
  assign wr_led = dph_r & dwr_r & hready & (da_r == plmc_pkg::LED_CONTROL_ADDR);
  assign wr_phy = dph_r & dwr_r & hready & (da_r == plmc_pkg::PHY_CONTROL_ADDR);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_ready_high: assert property (hreadyout) else $error("slave inserted a wait state");
  a_resp_okay: assert property (!hresp) else $error("slave gave an error response");
  a_idle_rdata: assert property (!dph_r |-> hrdata == 32'h0) else $error("read data outside data phase");
  a_upper_zero: assert property (hrdata[31:16] == 16'h0) else $error("upper read half not zero");
  a_led_rsvd: assert property (rd_led |-> hrdata[15:11] == 5'h00) else $error("led reserved bits set");
  a_phy_rsvd: assert property (rd_phy |-> hrdata[10:8] == 3'h0) else $error("phy reserved bits set");
  a_swap_follow: assert property (wr_phy |-> ##[1:2] pair_swap == wd_r[14])
    else $error("pair swap did not follow write");
  a_auto_follow: assert property (wr_phy |-> ##[1:2] auto_crossover_en == wd_r[15])
    else $error("auto crossover did not follow write");
  a_force_pin: assert property (wr_led && hwdata[4] |-> ##[1:3] first_led_pin == wd_r[1])
    else $error("forced led level not driven");
  a_rx_needs_fd: assert property ((!an_state.full_duplex) [*6] |-> !pause_rx_en)
    else $error("pause receive without full duplex");
  a_tx_needs_an: assert property ((!an_state.an_done) [*6] |-> !pause_tx_en)
    else $error("pause transmit without negotiation");

  c_phy_write: cover property (wr_phy);
  c_irq_rise: cover property ($rose(irq));
  c_pause_rx: cover property ($rose(pause_rx_en));
  c_led_rise: cover property ($rose(first_led_pin));
endmodule : plmc_monitor

// >>> plmc_far_model.sv
// far side model: strap resistors and the negotiating link partner
`timescale 1ns/1ns
module plmc_far_model (
  input  wire logic             ext,
  input  wire logic             pol,
  input  wire logic             ax,
  input  wire logic             fx,
  input  wire logic [4:0]       addr,
  input  wire logic             up,
  input  wire logic             fd,
  input  wire logic [1:0]       lp,
  input  wire logic [1:0]       pp,
  output plmc_pkg::plmc_strap_t strap_pins,
  output plmc_pkg::plmc_an_t    an_state
);
  // straps are static resistors, only latched by the device at reset
  assign strap_pins = {ext, pol, ax, fx, addr};
  // negotiation only completes while the partner holds the link, always at 100 mb/s
  assign an_state = {up, up & fd, up, up, lp, pp};
endmodule : plmc_far_model

// >>> phy_led_and_mdix_control_tb_top.sv
// self-checking bench for the led and crossover control block
`timescale 1ns/1ns
module phy_led_and_mdix_control_tb_top;
  logic                  hclk    = 1'b0;
  logic                  hresetn = 1'b0;
  logic [31:0]           haddr   = 32'h0;
  logic [1:0]            htrans  = 2'h0;
  logic                  hwrite  = 1'b0;
  logic [31:0]           hwdata  = 32'h0;
  logic                  act     = 1'b0;
  logic                  ext = 1'b0, pol = 1'b0, ax = 1'b0, fx = 1'b0, up = 1'b0, fd = 1'b0;
  logic [1:0]            lp = 2'h0, pp = 2'h0;
  logic [31:0]           lfsr = 32'h1C1A;
  logic [4:0]            addr = 5'h1A;
  logic [31:0]           hrdata, q;
  logic [15:0]           e, w;
  logic                  hreadyout, hresp, led, swp, ax_en, prx, ptx, irq;
  plmc_pkg::plmc_strap_t strap_pins;
  plmc_pkg::plmc_an_t    an_state;
  int                    num_errors = 0;
  int                    checked    = 0;

  always #20 hclk = ~hclk;

  plmc_far_model u_plmc_far_model (.ext(ext), .pol(pol), .ax(ax), .fx(fx), .addr(addr), .up(up), .fd(fd),
    .lp(lp), .pp(pp), .strap_pins(strap_pins), .an_state(an_state));
  plmc_top u_plmc_top (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .strap_pins(strap_pins), .an_state(an_state),
    .link_activity(act), .first_led_pin(led), .pair_swap(swp), .auto_crossover_en(ax_en),
    .pause_rx_en(prx), .pause_tx_en(ptx), .irq(irq));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand

  // status bits from the pause resolution table, gated by full duplex link
  function automatic logic [15:0] exp_stat(input logic [1:0] l, input logic [1:0] p, input logic f);
    logic rx;
    logic tx;
    rx = (l[0] & p[0]) | (l[0] & l[1] & ~p[0] & p[1]);
    tx = (l[0] & p[0]) | (~l[0] & l[1] & p[0] & p[1]);
    return {2'b00, rx & f, tx & f, f, 11'h000};
  endfunction : exp_stat

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d);
    haddr  <= {22'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : xfer

  task automatic rd(input logic [9:0] a, input logic [15:0] x);
    xfer(1'b0, a, 32'h0);
    chk("rdata", q, {16'h0, x});
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask : idle

  task automatic report_and_stop;
    if (num_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    addr = lfsr[4:0];
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    idle(6);
    rd(plmc_pkg::LED_CONTROL_ADDR, 16'h0400);
    rd(plmc_pkg::PHY_CONTROL_ADDR, {11'h400, addr});
    rd(plmc_pkg::IRQ_STATUS_ADDR, 16'h0004);
    rd(plmc_pkg::IRQ_STATUS_ADDR, 16'h0000);
    xfer(1'b1, 10'h070, 32'hFFFF);
    rd(10'h070, 16'h0000);
    chk("irq", irq, 32'h0);
    xfer(1'b1, plmc_pkg::IRQ_MASK_ADDR, 32'h1);
    up <= 1'b1;
    fd <= 1'b1;
    idle(5);
    chk("irq", irq, 32'h1);
    rd(plmc_pkg::IRQ_STATUS_ADDR, 16'h0001);
    idle(1);
    chk("irq", irq, 32'h0);
    // every advertisement combination, then a half duplex link
    for (int i = 0; i < 17; i++) begin
      lp <= i[1:0];
      pp <= i[3:2];
      fd <= (i < 16);
      e = exp_stat(i[1:0], i[3:2], i < 16);
      idle(5);
      rd(plmc_pkg::PHY_CONTROL_ADDR, e | {11'h400, addr});
      idle(2);
      chk("pause_rx", prx, e[13]);
      chk("pause_tx", ptx, e[12]);
    end
    for (int i = 0; i < 4; i++) begin
      lfsr = next_rand(lfsr);
      w = {lfsr[15:11], i[1:0], lfsr[8:0]};
      xfer(1'b1, plmc_pkg::LED_CONTROL_ADDR, {16'h0, w});
      rd(plmc_pkg::LED_CONTROL_ADDR, w & 16'h07FF);
    end
    up <= 1'b0;
    // forced low, forced high, then unlit at both polarities
    for (int i = 0; i < 4; i++) begin
      w = (i < 2) ? 16'h0010 | 16'(i << 1) : ((i == 3) ? 16'h0080 : 16'h0000);
      xfer(1'b1, plmc_pkg::LED_CONTROL_ADDR, {16'h0, w});
      idle(6);
      chk("led", led, (i == 1 || i == 2));
    end
    xfer(1'b1, plmc_pkg::PHY_CONTROL_ADDR, 32'h0080);
    rd(plmc_pkg::PHY_CONTROL_ADDR, {11'h004, addr});
    act <= 1'b1;
    idle(6);
    chk("led", led, 32'h1);
    act <= 1'b0;
    idle(6);
    chk("led", led, 32'h0);
    for (int i = 0; i < 3; i++) begin
      lfsr = next_rand(lfsr);
      xfer(1'b1, plmc_pkg::PHY_CONTROL_ADDR, lfsr);
      rd(plmc_pkg::PHY_CONTROL_ADDR, (lfsr[15:0] & 16'hC0E0) | {11'h0, addr});
      idle(2);
      chk("pair_swap", swp, lfsr[14]);
      chk("auto_x", ax_en, lfsr[15]);
    end
    // extended pin mode with auto crossover strapped off
    ext <= 1'b1;
    pol <= 1'b1;
    fx <= 1'b1;
    addr <= lfsr[20:16];
    hresetn <= 1'b0;
    idle(2);
    hresetn <= 1'b1;
    idle(6);
    rd(plmc_pkg::LED_CONTROL_ADDR, 16'h0480);
    rd(plmc_pkg::PHY_CONTROL_ADDR, {11'h200, addr});
    report_and_stop();
  end

  // run needs well under a thousand cycles
  initial begin
    #(40 * 20000);
    num_errors++;
    report_and_stop();
  end
endmodule : phy_led_and_mdix_control_tb_top

bind plmc_top plmc_monitor u_plmc_monitor (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .an_state(an_state), .first_led_pin(first_led_pin),
  .pair_swap(pair_swap), .auto_crossover_en(auto_crossover_en), .pause_rx_en(pause_rx_en),
  .pause_tx_en(pause_tx_en), .irq(irq));
